// >>> sac_defs.vh
// shared constants for the stack addressing and sample control block
`ifndef SAC_DEFS_VH
`define SAC_DEFS_VH
`define SAC_AW 8
`define SAC_DW 16
`define SAC_A_PART_CONFIG 8'h00
`define SAC_A_PART_CONTROL 8'h01
`define SAC_A_NODE_ID 8'h02
`define SAC_A_BALANCE_CONFIG 8'h03
`define SAC_A_BALANCE_ENABLE 8'h04
`define SAC_A_SAMPLE_REPEAT 8'h05
`define SAC_A_CELL_CHAN 8'h06
`define SAC_A_AUX_CHAN 8'h07
`define SAC_A_FAULT_MASK 8'h08
`define SAC_A_FAULT_STATUS 8'h09
`define SAC_A_GAIN_CORR 8'h0A
`define SAC_A_OFFSET_CORR 8'h0B
`define SAC_A_UART_CONFIG 8'h0C
`define SAC_A_GPIO_CONFIG 8'h0D
`define SAC_A_SEQ_STATUS 8'h0E
`define SAC_A_MONITOR 8'h0F
`define SAC_B_ID_SOURCE 0
`define SAC_B_SELF_NUM 0
`define SAC_B_BAL_POLICY 0
`define SAC_B_ORDER 4
`define SAC_B_MON_EN 0
`define SAC_B_REQ 1
`define SAC_F_REPEAT 2:0
`define SAC_F_NODE 4:0
`define SAC_NODE_RESET 5'h00
`define SAC_REPEAT_RESET 3'h7
`define SAC_CELL_RESET 16'hFFFF
`define SAC_AUX_RESET 8'h00
`define SAC_FMASK_RESET 16'h0003
`define SAC_UART_RESET 16'h0001
`define SAC_GPIO_RESET 16'h0000
`define SAC_ZERO16 16'h0000
`define SAC_LOCK_NS 2000
`define SAC_CLK_NS 8
`define SAC_FIRST_NS 60000
`define SAC_LATER_NS 12600
`define SAC_MON_PERIOD 16'h03FF
`endif

// >>> sac_sequencer.v
// oversample channel sequencer
`timescale 1ns/100ps
`include "sac_defs.vh"
module sac_sequencer (
    input wire sys_clk,
    input wire srst,
    input wire start,
    input wire oversample_order,
    input wire [2:0] repeats,
    input wire [15:0] cell_en,
    input wire [7:0] aux_en,
    output reg busy,
    output reg [4:0] channel,
    output reg [2:0] pass,
    output reg sample_strobe
);
    localparam FIRST_CYC = (`SAC_FIRST_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS;
    localparam LATER_CYC = (`SAC_LATER_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS;
    localparam S_IDLE = 1'b0;
    localparam S_RUN = 1'b1;
    reg state;
    reg [12:0] timer;
    reg first;
    wire [23:0] en = {aux_en, cell_en};
    // next enabled channel above c, 5'h1F if none
    function [4:0] next_chan;
        input [4:0] c;
        input [23:0] m;
        integer i;
        begin
            next_chan = 5'h1F;
            for (i = 23; i >= 0; i = i - 1) begin
                if (m[i] && (i > c)) begin
                    next_chan = i[4:0];
                end
            end
        end
    endfunction
    wire [4:0] first_chan = m0(en);
    function [4:0] m0;
        input [23:0] m;
        integer i;
        begin
            m0 = 5'h1F;
            for (i = 23; i >= 0; i = i - 1) begin
                if (m[i]) begin
                    m0 = i[4:0];
                end
            end
        end
    endfunction
    wire [4:0] nc = next_chan(channel, en);
    always @(posedge sys_clk) begin
        if (srst) begin
            state <= S_IDLE;
            busy <= 1'b0;
            channel <= 5'h00;
            pass <= 3'h0;
            timer <= 13'h0000;
            first <= 1'b0;
            sample_strobe <= 1'b0;
        end else begin
            sample_strobe <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (start && first_chan != 5'h1F) begin
                        state <= S_RUN;
                        busy <= 1'b1;
                        channel <= first_chan;
                        pass <= 3'h0;
                        first <= 1'b1;
                        timer <= FIRST_CYC[12:0];
                    end
                end
                S_RUN: begin
                    if (timer > 13'h0001) begin
                        timer <= timer - 13'h0001;
                    end else begin
                        sample_strobe <= 1'b1;
                        first <= 1'b0;
                        timer <= LATER_CYC[12:0];
                        if (!oversample_order) begin
                            // all repeats of one channel first
                            if (pass != repeats) begin
                                pass <= pass + 3'h1;
                            end else if (nc != 5'h1F) begin
                                pass <= 3'h0;
                                channel <= nc;
                            end else begin
                                state <= S_IDLE;
                                busy <= 1'b0;
                            end
                        end else begin
                            // sweep all channels, then repeat
                            if (nc != 5'h1F) begin
                                channel <= nc;
                            end else if (pass != repeats) begin
                                pass <= pass + 3'h1;
                                channel <= first_chan;
                            end else begin
                                state <= S_IDLE;
                                busy <= 1'b0;
                            end
                        end
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule // sac_sequencer

// >>> sac_control.v
// stack addressing, lockout, monitoring and defaults control
`timescale 1ns/100ps
`include "sac_defs.vh"
// Contract
// - trigger with id source 1 enters self-numbering
// - high-side transmit off for one frame
// - node id writable during self-numbering
// - node id write ignored otherwise
// - after frame, lock id, transmitter back
// - auto-monitor samples, never transmits
// - fault while balancing blocks writes 2us
// - order 0: all repeats per channel
// - order 1: sweep channels, repeat sweeps
// - order affects cell and aux only
// - shipped node id is zero
// - digital faults unmasked, cell faults masked
// - unmasked fault drives alarm and chain pair
// - default 8 samples, 60us then 12.6us
// - default all cells on, aux off
// - default no gain or offset correction
// - default uart enabled at 250 Kbaud
// - default gpio inputs, no pulls
// - reset reloads stored node id
// - id source 0 takes id from pins
module sac_control (
    input wire sys_clk,
    input wire srst,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire frame_done,
    input wire [4:0] gpio_id_pins,
    input wire [4:0] stored_node_id,
    input wire [15:0] fault_events,
    input wire other_sample_req,
    output wire high_tx_enable,
    output reg alarm_n,
    output reg fault_chain_pair_p,
    output reg fault_chain_pair_n,
    output reg monitor_sample_tx,
    output wire [4:0] node_id,
    output wire [4:0] sample_channel,
    output wire sample_strobe,
    output wire sample_busy
);
    localparam LOCK_CYC = `SAC_LOCK_NS / `SAC_CLK_NS;
    reg [4:0] pin_s1;
    reg [4:0] pin_s2;
    reg [15:0] fev_s1;
    reg [15:0] fev_s2;
    reg frm_s1;
    reg frm_s2;
    reg frm_d;
    reg id_source;
    reg self_num;
    reg [4:0] node_id_field;
    reg balance_fault_policy;
    reg [15:0] balance_enable_mask;
    reg [2:0] repeat_cnt;
    reg oversample_order;
    reg [15:0] cell_voltage_channel;
    reg [7:0] aux_chan;
    reg [15:0] fault_mask;
    reg [15:0] fault_status;
    reg [15:0] gain_corr;
    reg [15:0] offset_corr;
    reg [15:0] uart_cfg;
    reg [15:0] gpio_cfg;
    reg mon_en;
    reg [15:0] mon_timer;
    reg [8:0] lock_cnt;
    reg load_pending;
    reg conv_start;
    wire frame_pulse = frm_s2 & ~frm_d;
    wire [15:0] new_fault = fev_s2 & ~fault_status;
    wire fault_hit = |(new_fault & ~fault_mask);
    wire locked = (lock_cnt != 9'h000);
    wire wr_ok = reg_wr & ~locked;
    wire [15:0] seq_cells = cell_voltage_channel;
    wire [2:0] seq_pass;
    wire [4:0] seq_chan;
    assign node_id = node_id_field;
    assign high_tx_enable = ~self_num;
    assign sample_channel = seq_chan;
    function is_addr;
        input [7:0] a;
        input [7:0] b;
        begin
            is_addr = (a == b);
        end
    endfunction
    always @(posedge sys_clk) begin
        if (srst) begin
            pin_s1 <= 5'h00;
            pin_s2 <= 5'h00;
            fev_s1 <= `SAC_ZERO16;
            fev_s2 <= `SAC_ZERO16;
            frm_s1 <= 1'b0;
            frm_s2 <= 1'b0;
            frm_d <= 1'b0;
        end else begin
            pin_s1 <= gpio_id_pins;
            pin_s2 <= pin_s1;
            fev_s1 <= fault_events;
            fev_s2 <= fev_s1;
            frm_s1 <= frame_done;
            frm_s2 <= frm_s1;
            frm_d <= frm_s2;
        end
    end
    always @(posedge sys_clk) begin
        if (srst) begin
            id_source <= 1'b1;
            self_num <= 1'b0;
            node_id_field <= `SAC_NODE_RESET;
            load_pending <= 1'b1;
            balance_fault_policy <= 1'b0;
            balance_enable_mask <= `SAC_ZERO16;
            repeat_cnt <= `SAC_REPEAT_RESET;
            oversample_order <= 1'b0;
            cell_voltage_channel <= `SAC_CELL_RESET;
            aux_chan <= `SAC_AUX_RESET;
            fault_mask <= `SAC_FMASK_RESET;
            gain_corr <= `SAC_ZERO16;
            offset_corr <= `SAC_ZERO16;
            uart_cfg <= `SAC_UART_RESET;
            gpio_cfg <= `SAC_GPIO_RESET;
            mon_en <= 1'b0;
        end else begin
            if (load_pending) begin
                load_pending <= 1'b0;
                // reload stored id, or pins when source is 0
                node_id_field <= id_source ? stored_node_id : pin_s2;
            end
            if (frame_pulse && self_num) begin
                self_num <= 1'b0;
            end
            if (wr_ok) begin
                if (is_addr(reg_addr, `SAC_A_PART_CONFIG)) begin
                    id_source <= reg_wdata[`SAC_B_ID_SOURCE];
                end else if (is_addr(reg_addr, `SAC_A_PART_CONTROL)) begin
                    if (reg_wdata[`SAC_B_SELF_NUM]) begin
                        if (id_source) begin
                            self_num <= 1'b1;
                        end else begin
                            node_id_field <= pin_s2;
                        end
                    end
                end else if (is_addr(reg_addr, `SAC_A_NODE_ID)) begin
                    if (self_num) begin
                        node_id_field <= reg_wdata[`SAC_F_NODE];
                    end
                end else if (is_addr(reg_addr, `SAC_A_BALANCE_CONFIG)) begin
                    balance_fault_policy <= reg_wdata[`SAC_B_BAL_POLICY];
                end else if (is_addr(reg_addr, `SAC_A_BALANCE_ENABLE)) begin
                    balance_enable_mask <= reg_wdata;
                end else if (is_addr(reg_addr, `SAC_A_SAMPLE_REPEAT)) begin
                    repeat_cnt <= reg_wdata[`SAC_F_REPEAT];
                    oversample_order <= reg_wdata[`SAC_B_ORDER];
                end else if (is_addr(reg_addr, `SAC_A_CELL_CHAN)) begin
                    cell_voltage_channel <= reg_wdata;
                end else if (is_addr(reg_addr, `SAC_A_AUX_CHAN)) begin
                    aux_chan <= reg_wdata[7:0];
                end else if (is_addr(reg_addr, `SAC_A_FAULT_MASK)) begin
                    fault_mask <= reg_wdata;
                end else if (is_addr(reg_addr, `SAC_A_GAIN_CORR)) begin
                    gain_corr <= reg_wdata;
                end else if (is_addr(reg_addr, `SAC_A_OFFSET_CORR)) begin
                    offset_corr <= reg_wdata;
                end else if (is_addr(reg_addr, `SAC_A_UART_CONFIG)) begin
                    uart_cfg <= reg_wdata;
                end else if (is_addr(reg_addr, `SAC_A_GPIO_CONFIG)) begin
                    gpio_cfg <= reg_wdata;
                end else if (is_addr(reg_addr, `SAC_A_MONITOR)) begin
                    mon_en <= reg_wdata[`SAC_B_MON_EN];
                end
            end
        end
    end
    // fault status: set wins over write-one-to-clear
    always @(posedge sys_clk) begin
        if (srst) begin
            fault_status <= `SAC_ZERO16;
            lock_cnt <= 9'h000;
            alarm_n <= 1'b1;
            fault_chain_pair_p <= 1'b0;
            fault_chain_pair_n <= 1'b1;
        end else begin
            if (wr_ok && is_addr(reg_addr, `SAC_A_FAULT_STATUS)) begin
                fault_status <= (fault_status & ~reg_wdata) | fev_s2;
            end else begin
                fault_status <= fault_status | fev_s2;
            end
            if (fault_hit && balance_fault_policy && (balance_enable_mask != `SAC_ZERO16)) begin
                lock_cnt <= LOCK_CYC[8:0];
            end else if (locked) begin
                lock_cnt <= lock_cnt - 9'h001;
            end
            alarm_n <= ~|(fault_status & ~fault_mask);
            fault_chain_pair_p <= |(fault_status & ~fault_mask);
            fault_chain_pair_n <= ~|(fault_status & ~fault_mask);
        end
    end
    // autonomous monitoring: periodic conversions, results kept local
    always @(posedge sys_clk) begin
        if (srst) begin
            mon_timer <= `SAC_ZERO16;
            conv_start <= 1'b0;
            monitor_sample_tx <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            monitor_sample_tx <= 1'b0;
            if (mon_en) begin
                if (mon_timer == `SAC_ZERO16) begin
                    mon_timer <= `SAC_MON_PERIOD;
                    conv_start <= 1'b1;
                end else begin
                    mon_timer <= mon_timer - 16'h0001;
                end
            end else begin
                mon_timer <= `SAC_ZERO16;
                if (other_sample_req || (wr_ok && is_addr(reg_addr, `SAC_A_MONITOR)
                        && reg_wdata[`SAC_B_REQ])) begin
                    conv_start <= 1'b1;
                end
            end
        end
    end
    always @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata <= `SAC_ZERO16;
        end else if (reg_rd) begin
            if (is_addr(reg_addr, `SAC_A_PART_CONFIG)) begin
                reg_rdata <= {15'h0000, id_source};
            end else if (is_addr(reg_addr, `SAC_A_PART_CONTROL)) begin
                reg_rdata <= {15'h0000, self_num};
            end else if (is_addr(reg_addr, `SAC_A_NODE_ID)) begin
                reg_rdata <= {11'h000, node_id_field};
            end else if (is_addr(reg_addr, `SAC_A_BALANCE_CONFIG)) begin
                reg_rdata <= {15'h0000, balance_fault_policy};
            end else if (is_addr(reg_addr, `SAC_A_BALANCE_ENABLE)) begin
                reg_rdata <= balance_enable_mask;
            end else if (is_addr(reg_addr, `SAC_A_SAMPLE_REPEAT)) begin
                reg_rdata <= {11'h000, oversample_order, 1'b0, repeat_cnt};
            end else if (is_addr(reg_addr, `SAC_A_CELL_CHAN)) begin
                reg_rdata <= cell_voltage_channel;
            end else if (is_addr(reg_addr, `SAC_A_AUX_CHAN)) begin
                reg_rdata <= {8'h00, aux_chan};
            end else if (is_addr(reg_addr, `SAC_A_FAULT_MASK)) begin
                reg_rdata <= fault_mask;
            end else if (is_addr(reg_addr, `SAC_A_FAULT_STATUS)) begin
                reg_rdata <= fault_status;
            end else if (is_addr(reg_addr, `SAC_A_GAIN_CORR)) begin
                reg_rdata <= gain_corr;
            end else if (is_addr(reg_addr, `SAC_A_OFFSET_CORR)) begin
                reg_rdata <= offset_corr;
            end else if (is_addr(reg_addr, `SAC_A_UART_CONFIG)) begin
                reg_rdata <= uart_cfg;
            end else if (is_addr(reg_addr, `SAC_A_GPIO_CONFIG)) begin
                reg_rdata <= gpio_cfg;
            end else if (is_addr(reg_addr, `SAC_A_SEQ_STATUS)) begin
                reg_rdata <= {7'h00, seq_pass, sample_busy, seq_chan};
            end else if (is_addr(reg_addr, `SAC_A_MONITOR)) begin
                reg_rdata <= {15'h0000, mon_en};
            end else begin
                reg_rdata <= `SAC_ZERO16;
            end
        end
    end
    // only cell and aux channels follow the order bit
    sac_sequencer u_seq (
        .sys_clk(sys_clk),
        .srst(srst),
        .start(conv_start),
        .oversample_order(oversample_order),
        .repeats(repeat_cnt),
        .cell_en(seq_cells),
        .aux_en(aux_chan),
        .busy(sample_busy),
        .channel(seq_chan),
        .pass(seq_pass),
        .sample_strobe(sample_strobe)
    );
endmodule // sac_control

// >>> sac_control_props.sv
// assertions on the ports of the stack addressing control block
`timescale 1ns/100ps
module sac_control_props (
    input wire sys_clk,
    input wire srst,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    input wire frame_done,
    input wire high_tx_enable,
    input wire alarm_n,
    input wire fault_chain_pair_p,
    input wire fault_chain_pair_n,
    input wire monitor_sample_tx,
    input wire [4:0] node_id,
    input wire sample_strobe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence id_write_s;
        reg_wr && reg_addr == 8'h02 && !high_tx_enable && !frame_done;
    endsequence
    no_sample_tx_a: assert property (monitor_sample_tx == 1'b0)
        else $error("monitoring drove sample transmit");
    alarm_pair_a: assert property (alarm_n == fault_chain_pair_n)
        else $error("alarm and fault pair disagree");
    pair_diff_a: assert property (fault_chain_pair_p != fault_chain_pair_n)
        else $error("fault pair not differential");
    enter_trigger_a: assert property ($fell(high_tx_enable) |->
        $past(reg_wr && reg_addr == 8'h01 && reg_wdata[0]))
        else $error("transmitter off without trigger write");
    id_accept_a: assert property (id_write_s |=> node_id == $past(reg_wdata[4:0]))
        else $error("node id write lost in self numbering");
    id_locked_a: assert property ($changed(node_id) |-> $past(srst) || $past(srst, 2) ||
        !$past(high_tx_enable) || $past(reg_wr && reg_addr == 8'h01))
        else $error("node id changed while locked");
    frame_end_a: assert property ($rose(frame_done) && !high_tx_enable
        |-> ##[1:8] high_tx_enable)
        else $error("frame did not end self numbering");
    one_frame_a: assert property ($rose(high_tx_enable) |-> $past(frame_done, 2)
        || $past(frame_done, 3) || $past(frame_done, 4) || $past(frame_done, 5))
        else $error("transmitter back without a frame");
    unmapped_a: assert property (reg_rd && reg_addr > 8'h0F |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    strobe_pulse_a: assert property (sample_strobe |=> !sample_strobe [*8])
        else $error("sample strobe too close");
    self_num_c: cover property ($fell(high_tx_enable));
    alarm_c: cover property ($fell(alarm_n));
    sample_c: cover property (sample_strobe);
endmodule // sac_control_props

// >>> sac_link_model.sv
// link side model: delivers one received frame per send request
`timescale 1ns/100ps
module sac_link_model (
    input wire sys_clk,
    input wire srst,
    input wire send,
    output reg frame_done
);
    reg [3:0] cnt;
    // one broadcast frame per request, level held four cycles
    always @(posedge sys_clk) begin
        if (srst) begin
            cnt <= 4'h0;
            frame_done <= 1'b0;
        end else begin
            if (send)
                cnt <= 4'h7;
            else if (cnt != 4'h0)
                cnt <= cnt - 4'h1;
            frame_done <= (cnt > 4'h0) && (cnt < 4'h5);
        end
    end
endmodule // sac_link_model

// >>> tb_stack_addressing_sample_control.sv
// self-checking bench for the stack addressing control block
`timescale 1ns/100ps
module tb_stack_addressing_sample_control;
    reg sys_clk, srst, reg_wr, reg_rd, send;
    reg [7:0] reg_addr;
    reg [15:0] reg_wdata, fault_events, d;
    reg [4:0] gpio_id_pins, stored_node_id;
    wire [15:0] reg_rdata;
    wire frame_done, high_tx_enable, alarm_n, fp, fn, mtx, sample_strobe, sample_busy;
    wire [4:0] node_id, sample_channel;
    integer error_cnt, n_tests, cyc, i;
    reg [7:0] da [0:9];
    reg [15:0] dv [0:9];
    sac_control dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .frame_done(frame_done), .gpio_id_pins(gpio_id_pins),
        .stored_node_id(stored_node_id), .fault_events(fault_events),
        .other_sample_req(1'b0), .high_tx_enable(high_tx_enable), .alarm_n(alarm_n),
        .fault_chain_pair_p(fp), .fault_chain_pair_n(fn), .monitor_sample_tx(mtx),
        .node_id(node_id), .sample_channel(sample_channel),
        .sample_strobe(sample_strobe), .sample_busy(sample_busy));
    sac_link_model link (.sys_clk(sys_clk), .srst(srst), .send(send), .frame_done(frame_done));
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d, mismatches %0d", n_tests, error_cnt);
            if (error_cnt == 0 && n_tests > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    task wr(input [7:0] a, input [15:0] v);
        begin
            @(posedge sys_clk);
            reg_addr <= a;
            reg_wdata <= v;
            reg_wr <= 1'b1;
            @(posedge sys_clk);
            reg_wr <= 1'b0;
            #1;
        end
    endtask
    task rd(input [7:0] a, output [15:0] v);
        begin
            @(posedge sys_clk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge sys_clk);
            reg_rd <= 1'b0;
            #1;
            v = reg_rdata;
        end
    endtask
    task frame;
        begin
            @(posedge sys_clk);
            send <= 1'b1;
            @(posedge sys_clk);
            send <= 1'b0;
            repeat (14) @(posedge sys_clk);
        end
    endtask
    task do_reset;
        begin
            srst <= 1'b1;
            repeat (4) @(posedge sys_clk);
            srst <= 1'b0;
            repeat (2) @(posedge sys_clk);
        end
    endtask
    // four samples on two cells, channel order from the expectation word
    task run_seq(input [15:0] rep, input [19:0] exp);
        integer k, w;
        reg [4:0] ch;
        begin
            wr(8'h05, rep);
            wr(8'h0F, 16'h0002);
            for (k = 0; k < 4; k = k + 1) begin
                w = 0;
                do begin
                    ch = sample_channel;
                    @(posedge sys_clk);
                    #1;
                    w = w + 1;
                end while (sample_strobe !== 1'b1 && w < 20000);
                chk({11'h000, ch}, {11'h000, exp[19-5*k -: 5]});
                if (k == 1)
                    chk(w[15:0], 16'h0627);
            end
            w = 0;
            while (sample_busy !== 1'b0 && w < 100) begin
                @(posedge sys_clk);
                w = w + 1;
            end
        end
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 40000) begin
            error_cnt = error_cnt + 1;
            tally_and_finish;
        end
    end
    initial begin
        error_cnt = 0;
        n_tests = 0;
        cyc = 0;
        srst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        send = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        fault_events = 16'h0000;
        gpio_id_pins = 5'h13;
        stored_node_id = 5'h00;
        da = '{8'h00, 8'h02, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0A, 8'h0B, 8'h0C, 8'h0D};
        dv = '{16'h0001, 16'h0000, 16'h0007, 16'hFFFF, 16'h0000, 16'h0003, 16'h0000,
            16'h0000, 16'h0001, 16'h0000};
        do_reset;
        for (i = 0; i < 10; i = i + 1) begin
            rd(da[i], d);
            chk(d, dv[i]);
        end
        rd(8'h0F, d);
        chk(d, 16'h0000);
        rd(8'h20, d);
        chk(d, 16'h0000);
        // node id locked outside self numbering
        wr(8'h02, 16'h0015);
        rd(8'h02, d);
        chk(d, 16'h0000);
        // self numbering with an id write, then locked again
        wr(8'h01, 16'h0001);
        chk({15'h0000, high_tx_enable}, 16'h0000);
        wr(8'h02, 16'h0005);
        rd(8'h02, d);
        chk(d, 16'h0005);
        frame;
        chk({15'h0000, high_tx_enable}, 16'h0001);
        wr(8'h02, 16'h0009);
        rd(8'h02, d);
        chk(d, 16'h0005);
        // a frame without an id write still ends the mode
        wr(8'h01, 16'h0001);
        frame;
        chk({15'h0000, high_tx_enable}, 16'h0001);
        wr(8'h02, 16'h000C);
        rd(8'h02, d);
        chk(d, 16'h0005);
        // id from pins when the id source is cleared
        wr(8'h00, 16'h0000);
        wr(8'h01, 16'h0001);
        repeat (6) @(posedge sys_clk);
        rd(8'h02, d);
        chk(d, 16'h0013);
        wr(8'h00, 16'h0001);
        // oversample ordering on two cells, two samples each
        wr(8'h06, 16'h0003);
        run_seq(16'h0001, {5'd0, 5'd0, 5'd1, 5'd1});
        run_seq(16'h0011, {5'd0, 5'd1, 5'd0, 5'd1});
        // masked cell fault leaves the alarm idle
        fault_events <= 16'h0001;
        repeat (8) @(posedge sys_clk);
        chk({14'h0000, alarm_n, fp}, 16'h0002);
        // unmasked fault while balancing: alarm and write lockout
        wr(8'h03, 16'h0001);
        wr(8'h04, 16'h0001);
        fault_events <= 16'h0005;
        repeat (6) @(posedge sys_clk);
        wr(8'h0A, 16'h0055);
        chk({14'h0000, alarm_n, fp}, 16'h0001);
        rd(8'h0A, d);
        chk(d, 16'h0000);
        repeat (300) @(posedge sys_clk);
        wr(8'h0A, 16'h0055);
        rd(8'h0A, d);
        chk(d, 16'h0055);
        // autonomous monitoring converts at once, sends nothing
        wr(8'h0F, 16'h0001);
        repeat (4) @(posedge sys_clk);
        rd(8'h0E, d);
        chk(d, 16'h0020);
        chk({15'h0000, mtx}, 16'h0000);
        // second reset reloads the stored id
        stored_node_id <= 5'h0B;
        do_reset;
        chk({11'h000, node_id}, 16'h000B);
        tally_and_finish;
    end
endmodule // tb_stack_addressing_sample_control
bind sac_control sac_control_props u_props (.sys_clk(sys_clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .frame_done(frame_done), .high_tx_enable(high_tx_enable),
    .alarm_n(alarm_n), .fault_chain_pair_p(fault_chain_pair_p),
    .fault_chain_pair_n(fault_chain_pair_n), .monitor_sample_tx(monitor_sample_tx),
    .node_id(node_id), .sample_strobe(sample_strobe));
